// >>> mmm_pkg.sv
// Constants, types and encodings of the data and program memory map.
`default_nettype none
package mmm_pkg;
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int PCH_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int GPR_WORDS = 128;
    localparam int SFR_SLOTS = 64;
    localparam int SYNC_W = 18;

    localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h004;

    // Data memory offsets
    localparam logic [7:0] ADDR_INDIRECT = 8'h00, ADDR_PCL = 8'h01, ADDR_PROG_COUNTER_HIGH_BUFFER = 8'h02, ADDR_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_POINTER = 8'h04, ADDR_PA_DIR = 8'h05, ADDR_PA_DATA = 8'h06, ADDR_PB_DIR = 8'h07;
    localparam logic [7:0] ADDR_PB_DATA = 8'h08, ADDR_PC_DIR = 8'h09, ADDR_PC_DATA = 8'h0A;
    localparam logic [7:0] ADDR_T0_CTL = 8'h10, ADDR_T0_RLD_LO = 8'h11, ADDR_T0_RLD_HI = 8'h12;
    localparam logic [7:0] ADDR_T0_CNT_LO = 8'h13, ADDR_T0_CNT_HI = 8'h14;
    localparam logic [7:0] ADDR_T1_CTL_A = 8'h15, ADDR_T1_CTL_B = 8'h16, ADDR_T1_RLD = 8'h17, ADDR_T1_CNT = 8'h18;
    localparam logic [7:0] ADDR_T2_CTL = 8'h19, ADDR_T2_RLD = 8'h1A, ADDR_T2_CNT = 8'h1B;
    localparam logic [7:0] ADDR_T3_CTL_A = 8'h1C, ADDR_T3_CTL_B = 8'h1D, ADDR_T3_RLD = 8'h1E, ADDR_T3_CNT = 8'h1F;
    localparam logic [7:0] ADDR_T4_CTL = 8'h20, ADDR_T4_RLD = 8'h21, ADDR_T4_CNT = 8'h22;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h25, ADDR_IRQ_FLAGS = 8'h26;
    localparam logic [7:0] ADDR_ADC_CTL_A = 8'h29, ADDR_ADC_CTL_B = 8'h2A, ADDR_ADC_SEL = 8'h2B;
    localparam logic [7:0] ADDR_ADC_RES_LO = 8'h2C, ADDR_ADC_RES_HI = 8'h2D;
    localparam logic [7:0] ADDR_SYSTEM_CLOCK_CONTROL = 8'h2F, ADDR_CLK_OUT = 8'h30, ADDR_PA_PULL = 8'h31, ADDR_PB_PULL = 8'h32;
    localparam logic [7:0] ADDR_PC_PULL = 8'h33, ADDR_PA_IRQ_EN = 8'h3A, ADDR_WATCHDOG_CONTROL = 8'h3D, ADDR_TBL_BANK = 8'h3E;
    localparam logic [7:0] SFR_LAST = 8'h3E, GPR_BASE = 8'h40, GPR_LAST = 8'hBF;

    // Implemented bit masks
    localparam logic [7:0] MASK_FULL = 8'hFF, MASK_NONE = 8'h00, MASK_PROG_COUNTER_HIGH_BUFFER = 8'h07, MASK_FLAGS = 8'h1F;
    localparam logic [7:0] MASK_PB = 8'h03, MASK_PB_DATA = 8'h07, MASK_PC = 8'hFE, MASK_TMR_CTL_B = 8'hCF;
    localparam logic [7:0] MASK_IRQ_FLAGS = 8'h7F, MASK_ADC_CTL_A = 8'hAF, MASK_ADC_CTL_B = 8'h87;
    localparam logic [7:0] MASK_ADC_SEL = 8'h0F, MASK_ADC_RES_LO = 8'hF0, MASK_SYSTEM_CLOCK_CONTROL = 8'h83;
    localparam logic [7:0] MASK_CLK_OUT = 8'hEF, MASK_WDT = 8'hE7, MASK_TBL_BANK = 8'h07;

    // Reset values
    localparam logic [7:0] RST_DIR = 8'hFF, RST_ZERO = 8'h00;
    localparam logic [PCH_W-1:0] RST_PROG_COUNTER_HIGH_BUFFER = 3'h0;

    // Field positions
    localparam int FLAG_C_BIT = 0, FLAG_DC_BIT = 1, FLAG_Z_BIT = 2, FLAG_PD_BIT = 3, FLAG_TO_BIT = 4;
    localparam int PB_INPUT_ONLY_BIT = 2;

    typedef enum logic [2:0] {
        MMM_PC_STEP = 3'h0, MMM_PC_HOLD = 3'h1, MMM_PC_JUMP = 3'h2, MMM_PC_CALL = 3'h3,
        MMM_PC_RET = 3'h4, MMM_PC_RETI = 3'h5, MMM_PC_IRQ = 3'h6
    } mmm_pc_op_t;

    typedef enum logic [1:0] {
        MMM_ST_RESET = 2'b00, MMM_ST_RUN = 2'b01, MMM_ST_BUBBLE = 2'b11
    } mmm_fsm_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mmm_req_t;

    typedef struct packed {
        logic we;
        logic z;
        logic dc;
        logic c;
    } mmm_flags_t;

    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } mmm_wr_t;

    typedef struct packed {
        logic [7:0] t0_lo;
        logic [7:0] t0_hi;
        logic [7:0] t1;
        logic [7:0] t2;
        logic [7:0] t3;
        logic [7:0] t4;
        logic [7:0] adc_lo;
        logic [7:0] adc_hi;
    } mmm_periph_t;

    typedef struct packed {
        logic [7:0] a_dir;
        logic [7:0] a_dat;
        logic [7:0] b_dir;
        logic [7:0] b_dat;
        logic [7:0] c_dir;
        logic [7:0] c_dat;
    } mmm_port_t;
endpackage : mmm_pkg
`default_nettype wire

// >>> mmm_memory_map.sv
// Program counter, return stack and data memory map of the 8-bit controller.
//Contract
//- An 11-bit program counter addresses 2K words of 16-bit program memory.
//- Every reset loads the program counter with 000h.
//- A taken interrupt sends program fetch to 004h.
//- Far call and far jump carry a full 11-bit target.
//- 45 special registers within 00h-3Eh, 128 general bytes at 40h-BFh.
//- Every location is reachable directly or through the indirect pointer.
//- Access to 00h goes to the location named by the pointer at 04h.
//- All special registers, program counter bytes included, decode in data space.
//- Instructions take one cycle; flow changes take two.
//- An eight-entry hardware return stack serves calls and interrupts.
//- Register locations and data path are 8 bits wide.
//- Unimplemented bits of mapped special registers read as zero.
//- Low external reset pin resets; the pin is also the input-only bit.
//- Indirect read of 00h gives 00h; indirect write there does nothing.
//- Program counter high bits load from the buffer only on low-byte writes.
`timescale 1ns/1ps
`default_nettype none
module mmm_memory_map
    import mmm_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic EXT_RESET_N_I,
    input wire logic [7:0] PIN_A_I,
    input wire logic [1:0] PIN_B_I,
    input wire logic [6:0] PIN_C_I,
    input wire mmm_req_t REQ_I,
    input wire mmm_flags_t FLAGS_I,
    input wire logic TIMEOUT_FLAG_I,
    input wire logic POWER_DOWN_FLAG_I,
    input wire mmm_periph_t PERIPH_I,
    input wire mmm_pc_op_t PC_OP_I,
    input wire logic [PC_W-1:0] PC_TARGET_I,
    output logic [PC_W-1:0] FETCH_ADDR_O,
    output logic FETCH_VALID_O,
    output logic [DATA_W-1:0] RD_DATA_O,
    output logic RD_VALID_O,
    output mmm_wr_t SFR_WR_O,
    output mmm_port_t PORT_O,
    output logic RESET_ACTIVE_O
);

    // Implemented bits of each register kept in local storage; zero means no storage
    function automatic logic [7:0] sfr_mask(input logic [7:0] a);
        logic [7:0] m;
        m = MASK_NONE;
        case (a)
            ADDR_POINTER, ADDR_PA_DIR, ADDR_PA_DATA, ADDR_T0_CTL, ADDR_T0_RLD_LO, ADDR_T0_RLD_HI,
            ADDR_T0_CNT_LO, ADDR_T0_CNT_HI, ADDR_T1_CTL_A, ADDR_T1_RLD, ADDR_T1_CNT, ADDR_T2_CTL,
            ADDR_T2_RLD, ADDR_T2_CNT, ADDR_T3_CTL_A, ADDR_T3_RLD, ADDR_T3_CNT, ADDR_T4_CTL,
            ADDR_T4_RLD, ADDR_T4_CNT, ADDR_IRQ_EN, ADDR_ADC_RES_HI, ADDR_PA_PULL,
            ADDR_PA_IRQ_EN: m = MASK_FULL;
            ADDR_PB_DIR, ADDR_PB_PULL: m = MASK_PB;
            ADDR_PB_DATA: m = MASK_PB_DATA;
            ADDR_PC_DIR, ADDR_PC_DATA, ADDR_PC_PULL: m = MASK_PC;
            ADDR_T1_CTL_B, ADDR_T3_CTL_B: m = MASK_TMR_CTL_B;
            ADDR_IRQ_FLAGS: m = MASK_IRQ_FLAGS;
            ADDR_ADC_CTL_A: m = MASK_ADC_CTL_A;
            ADDR_ADC_CTL_B: m = MASK_ADC_CTL_B;
            ADDR_ADC_SEL: m = MASK_ADC_SEL;
            ADDR_ADC_RES_LO: m = MASK_ADC_RES_LO;
            ADDR_SYSTEM_CLOCK_CONTROL: m = MASK_SYSTEM_CLOCK_CONTROL;
            ADDR_CLK_OUT: m = MASK_CLK_OUT;
            ADDR_WATCHDOG_CONTROL: m = MASK_WDT;
            ADDR_TBL_BANK: m = MASK_TBL_BANK;
            default: m = MASK_NONE;
        endcase
        return m;
    endfunction : sfr_mask

    // Timer 0-3 counts and ADC results: values come from another block and cannot be written here
    function automatic logic sfr_ro(input logic [7:0] a);
        return (a == ADDR_T0_CNT_LO) || (a == ADDR_T0_CNT_HI) || (a == ADDR_T1_CNT) || (a == ADDR_T2_CNT)
            || (a == ADDR_T3_CNT) || (a == ADDR_ADC_RES_LO) || (a == ADDR_ADC_RES_HI);
    endfunction : sfr_ro

    function automatic logic [7:0] sfr_reset(input logic [7:0] a);
        return ((a == ADDR_PA_DIR) || (a == ADDR_PB_DIR) || (a == ADDR_PC_DIR)) ? (RST_DIR & sfr_mask(a)) : RST_ZERO;
    endfunction : sfr_reset

    // Pin inputs: two-stage synchroniser
    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_sync;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_meta <= {SYNC_W{1'b1}};
            pin_sync <= {SYNC_W{1'b1}};
        end else begin
            pin_meta <= {EXT_RESET_N_I, PIN_A_I, PIN_B_I, PIN_C_I};
            pin_sync <= pin_meta;
        end
    end

    wire ext_rst_n_sync = pin_sync[17];
    wire [7:0] pin_a = pin_sync[16:9];
    wire [1:0] pin_b = pin_sync[8:7];
    wire [6:0] pin_c = pin_sync[6:0];
    // The same pin level acts as a reset and reads back as the input-only port bit
    wire pin_rst = !ext_rst_n_sync;

    // Core state
    mmm_fsm_t fsm;
    logic [PC_W-1:0] pc;
    logic [PCH_W-1:0] prog_counter_high_buffer;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic flag_z;
    logic flag_dc;
    logic flag_c;
    logic [SFR_SLOTS-1:0][7:0] sfr_q;
    logic [DATA_W-1:0] gpr [GPR_WORDS];

    // Address resolution
    wire [7:0] pointer = sfr_q[ADDR_POINTER[5:0]];
    wire [7:0] ea = (REQ_I.addr == ADDR_INDIRECT) ? pointer : REQ_I.addr;
    wire in_sfr = (ea <= SFR_LAST);
    wire in_gpr = (ea >= GPR_BASE) && (ea <= GPR_LAST);
    wire [7:0] gpr_off = ea - GPR_BASE;
    wire [7:0] ea_mask = in_sfr ? sfr_mask(ea) : MASK_NONE;
    wire running = (fsm == MMM_ST_RUN);
    wire wr_go = REQ_I.wr && running;
    wire rd_go = REQ_I.rd && running;
    wire pcl_wr = wr_go && (ea == ADDR_PCL);
    wire prog_counter_high_buffer_wr = wr_go && (ea == ADDR_PROG_COUNTER_HIGH_BUFFER);
    wire flags_wr = wr_go && (ea == ADDR_FLAGS);
    wire store_wr = wr_go && in_sfr && (ea_mask != MASK_NONE) && !sfr_ro(ea);

    // Program flow decode
    wire op_push = running && !pcl_wr && ((PC_OP_I == MMM_PC_CALL) || (PC_OP_I == MMM_PC_IRQ));
    wire op_pop = running && !pcl_wr && ((PC_OP_I == MMM_PC_RET) || (PC_OP_I == MMM_PC_RETI));
    wire op_far = running && !pcl_wr && ((PC_OP_I == MMM_PC_JUMP) || (PC_OP_I == MMM_PC_CALL));
    wire op_irq = running && !pcl_wr && (PC_OP_I == MMM_PC_IRQ);
    wire op_step = running && !pcl_wr && (PC_OP_I == MMM_PC_STEP);
    wire flow_change = pcl_wr || op_push || op_pop || op_far;
    wire [SP_W-1:0] sp_top = sp - 3'h1;
    wire [PC_W-1:0] pop_addr = stack[sp_top];

    logic [PC_W-1:0] next_pc;
    always_comb begin
        next_pc = pc;
        if (pcl_wr) begin
            next_pc = {prog_counter_high_buffer, REQ_I.wdata};
        end else if (op_irq) begin
            next_pc = IRQ_VECTOR;
        end else if (op_far) begin
            next_pc = PC_TARGET_I;
        end else if (op_pop) begin
            next_pc = pop_addr;
        end else if (op_step) begin
            next_pc = pc + 11'h001;
        end
    end

    // Buffer tracks the high bits on far transfers and plain returns, not on interrupt returns
    logic [PCH_W-1:0] next_prog_counter_high_buffer;
    always_comb begin
        next_prog_counter_high_buffer = prog_counter_high_buffer;
        if (prog_counter_high_buffer_wr) begin
            next_prog_counter_high_buffer = REQ_I.wdata[PCH_W-1:0];
        end else if (op_far) begin
            next_prog_counter_high_buffer = PC_TARGET_I[PC_W-1:8];
        end else if (op_pop && (PC_OP_I == MMM_PC_RET)) begin
            next_prog_counter_high_buffer = pop_addr[PC_W-1:8];
        end
    end

    // Sequencer: a flow change spends one extra cycle with fetch invalid
    mmm_fsm_t next_fsm;
    always_comb begin
        next_fsm = fsm;
        unique case (fsm)
            MMM_ST_RESET: next_fsm = MMM_ST_RUN;
            MMM_ST_RUN: next_fsm = flow_change ? MMM_ST_BUBBLE : MMM_ST_RUN;
            MMM_ST_BUBBLE: next_fsm = MMM_ST_RUN;
            default: next_fsm = MMM_ST_RESET;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fsm <= MMM_ST_RESET;
            pc <= RESET_VECTOR;
            prog_counter_high_buffer <= RST_PROG_COUNTER_HIGH_BUFFER;
            sp <= '0;
        end else if (pin_rst) begin
            fsm <= MMM_ST_RESET;
            pc <= RESET_VECTOR;
            prog_counter_high_buffer <= RST_PROG_COUNTER_HIGH_BUFFER;
            sp <= '0;
        end else begin
            fsm <= next_fsm;
            pc <= next_pc;
            prog_counter_high_buffer <= next_prog_counter_high_buffer;
            if (op_push) begin
                sp <= sp + 3'h1;
            end else if (op_pop) begin
                sp <= sp_top;
            end
        end
    end

    // Return stack wraps silently on overflow, as an eight-deep circular store
    wire [PC_W-1:0] next_pc_return = (PC_OP_I == MMM_PC_IRQ) ? pc : pc + 11'h001;
    always_ff @(posedge CLK_I) begin
        if (op_push && !pin_rst) begin
            stack[sp] <= next_pc_return;
        end
    end

    // Arithmetic flags: an instruction that updates flags overrides a software write to them
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag_z <= 1'b0;
            flag_dc <= 1'b0;
            flag_c <= 1'b0;
        end else if (pin_rst) begin
            flag_z <= 1'b0;
            flag_dc <= 1'b0;
            flag_c <= 1'b0;
        end else if (FLAGS_I.we && running) begin
            flag_z <= FLAGS_I.z;
            flag_dc <= FLAGS_I.dc;
            flag_c <= FLAGS_I.c;
        end else if (flags_wr) begin
            flag_z <= REQ_I.wdata[FLAG_Z_BIT];
            flag_dc <= REQ_I.wdata[FLAG_DC_BIT];
            flag_c <= REQ_I.wdata[FLAG_C_BIT];
        end
    end

    // Special register storage, one slot per address; unimplemented bits never store
    for (genvar i = 0; i < SFR_SLOTS; i++) begin : g_sfr
        localparam logic [7:0] SLOT = 8'(i);
        localparam logic [7:0] RV = sfr_reset(SLOT);
        localparam logic [7:0] WM = sfr_ro(SLOT) ? MASK_NONE : sfr_mask(SLOT);
        always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                sfr_q[i] <= RV;
            end else if (pin_rst) begin
                sfr_q[i] <= RV;
            end else if (store_wr && (ea == SLOT)) begin
                sfr_q[i] <= REQ_I.wdata & WM;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (wr_go && in_gpr) begin
            gpr[gpr_off[6:0]] <= REQ_I.wdata;
        end
    end

    // Read selection
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RST_ZERO;
        if (in_gpr) begin
            rd_mux = gpr[gpr_off[6:0]];
        end else if (in_sfr) begin
            unique case (ea)
                ADDR_INDIRECT: rd_mux = RST_ZERO;
                ADDR_PCL: rd_mux = pc[7:0];
                ADDR_PROG_COUNTER_HIGH_BUFFER: rd_mux = {5'h00, prog_counter_high_buffer} & MASK_PROG_COUNTER_HIGH_BUFFER;
                ADDR_FLAGS: rd_mux = {3'h0, TIMEOUT_FLAG_I, POWER_DOWN_FLAG_I, flag_z, flag_dc, flag_c} & MASK_FLAGS;
                ADDR_PA_DATA: rd_mux = pin_a;
                ADDR_PB_DATA: rd_mux = {5'h00, ext_rst_n_sync, pin_b};
                ADDR_PC_DATA: rd_mux = {pin_c, 1'b0};
                ADDR_T0_CNT_LO: rd_mux = PERIPH_I.t0_lo;
                ADDR_T0_CNT_HI: rd_mux = PERIPH_I.t0_hi;
                ADDR_T1_CNT: rd_mux = PERIPH_I.t1;
                ADDR_T2_CNT: rd_mux = PERIPH_I.t2;
                ADDR_T3_CNT: rd_mux = PERIPH_I.t3;
                ADDR_T4_CNT: rd_mux = PERIPH_I.t4;
                ADDR_ADC_RES_LO: rd_mux = PERIPH_I.adc_lo & MASK_ADC_RES_LO;
                ADDR_ADC_RES_HI: rd_mux = PERIPH_I.adc_hi;
                default: rd_mux = sfr_q[ea[5:0]] & ea_mask;
            endcase
        end
    end

    // Read data and write notifications leave through flip-flops
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= RST_ZERO;
            RD_VALID_O <= 1'b0;
            SFR_WR_O <= '0;
        end else begin
            RD_VALID_O <= rd_go && !pin_rst;
            if (rd_go) begin
                RD_DATA_O <= rd_mux;
            end
            SFR_WR_O.stb <= !pin_rst && (store_wr || pcl_wr || prog_counter_high_buffer_wr || flags_wr);
            SFR_WR_O.addr <= ea;
            SFR_WR_O.data <= REQ_I.wdata;
        end
    end

    assign FETCH_ADDR_O = pc;
    assign FETCH_VALID_O = running;
    assign RESET_ACTIVE_O = (fsm == MMM_ST_RESET);
    assign PORT_O.a_dir = sfr_q[ADDR_PA_DIR[5:0]];
    assign PORT_O.a_dat = sfr_q[ADDR_PA_DATA[5:0]];
    assign PORT_O.b_dir = sfr_q[ADDR_PB_DIR[5:0]];
    assign PORT_O.b_dat = sfr_q[ADDR_PB_DATA[5:0]];
    assign PORT_O.c_dir = sfr_q[ADDR_PC_DIR[5:0]];
    assign PORT_O.c_dat = sfr_q[ADDR_PC_DATA[5:0]];

    // Checks
    sequence s_bubble_then_fetch(logic [PC_W-1:0] a);
        (!FETCH_VALID_O && FETCH_ADDR_O == a) ##1 (FETCH_VALID_O && FETCH_ADDR_O == a);
    endsequence

    a_reset_vector: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $fell(pin_rst) |=> FETCH_VALID_O && (FETCH_ADDR_O == RESET_VECTOR))
        else $error("fetch does not start at reset vector");
    a_irq_vector: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        op_irq |=> s_bubble_then_fetch(IRQ_VECTOR))
        else $error("interrupt did not fetch from its vector");
    a_far_target: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        op_far |=> (FETCH_ADDR_O == $past(PC_TARGET_I)) && !FETCH_VALID_O)
        else $error("far transfer missed its target");
    a_step_single: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        op_step |=> FETCH_VALID_O && (FETCH_ADDR_O == $past(pc) + 11'h001))
        else $error("plain instruction did not advance by one");
    a_call_return: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (op_push && PC_OP_I == MMM_PC_CALL) ##3 (op_pop && $stable(sp)) |=> FETCH_ADDR_O == $past(pc, 4) + 11'h001)
        else $error("return address does not match call site");
    a_indirect_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (rd_go && REQ_I.addr == ADDR_INDIRECT && pointer == ADDR_INDIRECT) |=> RD_VALID_O && RD_DATA_O == RST_ZERO)
        else $error("indirect read of zero pointer not zero");
    a_pcl_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        pcl_wr |=> (FETCH_ADDR_O == {$past(prog_counter_high_buffer), $past(REQ_I.wdata)}) ##1 FETCH_VALID_O)
        else $error("low byte write did not load program counter");
    a_pch_hidden: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (prog_counter_high_buffer_wr && PC_OP_I == MMM_PC_HOLD) |=> FETCH_ADDR_O == $past(pc))
        else $error("buffer write moved the program counter");
    a_gap_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (rd_go && in_sfr && ea_mask == MASK_NONE && ea > ADDR_FLAGS && !sfr_ro(ea) && ea != ADDR_T4_CNT)
        |=> RD_DATA_O == RST_ZERO)
        else $error("unassigned location read nonzero");
    a_reserved_bits: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (rd_go && ea == ADDR_PB_DIR) |=> RD_DATA_O[7:2] == 6'h00)
        else $error("unimplemented bits read nonzero");

    // Data side: a store must be visible to the next read of the same byte
    sequence s_gpr_store_load;
        (wr_go && in_gpr) ##1 !wr_go ##1 (rd_go && ea == $past(ea, 2));
    endsequence

    a_gpr_readback: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        s_gpr_store_load |=> RD_DATA_O == $past(REQ_I.wdata, 3))
        else $error("general byte did not read back");
    a_read_answer: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        rd_go |=> RD_VALID_O)
        else $error("read not answered next cycle");
    a_read_single: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        !rd_go |=> !RD_VALID_O)
        else $error("read answer without request");
    a_idle_refused: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !running |=> !RD_VALID_O && !SFR_WR_O.stb)
        else $error("request taken while not running");
    a_indirect_nop: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (wr_go && REQ_I.addr == ADDR_INDIRECT && pointer == ADDR_INDIRECT) |=> !SFR_WR_O.stb)
        else $error("indirect write through zero pointer took effect");
    a_pin_reset: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        pin_rst |=> RESET_ACTIVE_O && (FETCH_ADDR_O == RESET_VECTOR))
        else $error("reset pin did not restart the sequencer");
    a_flag_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (flags_wr && !FLAGS_I.we) |=> {flag_z, flag_dc, flag_c} == $past(REQ_I.wdata[2:0]))
        else $error("software write to flags lost");
    a_unimpl_store: assert property (@(posedge CLK_I) disable iff (!RST_N_I || pin_rst)
        (store_wr && ea == ADDR_PC_DIR) |=> sfr_q[ADDR_PC_DIR[5:0]][0] == 1'b0)
        else $error("unimplemented bit was stored");
endmodule : mmm_memory_map
`default_nettype wire

// >>> mmm_core_model.sv
// Core-side model that issues register and program-flow requests to the memory map.
`timescale 1ns/1ps
`default_nettype none
module mmm_core_model
    import mmm_pkg::*;
(
    input wire logic CLK_I,
    input wire logic [DATA_W-1:0] RD_DATA_I,
    input wire logic RD_VALID_I,
    output mmm_req_t REQ_O,
    output mmm_pc_op_t PC_OP_O,
    output logic [PC_W-1:0] TARGET_O
);
    initial begin
        REQ_O = '0;
        PC_OP_O = MMM_PC_HOLD;
        TARGET_O = '0;
    end
    // Released fields carry inverted values so a stale copy is never mistaken for a live one
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(negedge CLK_I);
        REQ_O = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge CLK_I);
        REQ_O = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    endtask : write_byte
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge CLK_I);
        REQ_O = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(negedge CLK_I);
        data = RD_DATA_I;
        ok = RD_VALID_I;
        REQ_O = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
    endtask : read_byte
    // Ops issued in the bubble would be ignored, so the model parks on hold afterwards
    task automatic flow(input mmm_pc_op_t op, input logic [PC_W-1:0] tgt);
        @(negedge CLK_I);
        PC_OP_O = op;
        TARGET_O = tgt;
        @(negedge CLK_I);
        PC_OP_O = MMM_PC_HOLD;
        TARGET_O = ~tgt;
    endtask : flow
endmodule : mmm_core_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the memory map driven through the core model.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mmm_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ext_n = 1'b1, rd_valid, fetch_valid, reset_active, ok;
    logic [7:0] pin_a = 8'hC3, rd_data, d;
    logic [1:0] pin_b = 2'b10;
    logic [6:0] pin_c = 7'h55;
    logic [PC_W-1:0] fetch_addr, target;
    mmm_periph_t periph = '{t0_lo: 8'h3C, adc_lo: 8'h9C, default: 8'h00};
    mmm_req_t req;
    mmm_pc_op_t pc_op;
    mmm_wr_t sfr_wr;
    mmm_port_t port_out;
    int miscompares = 0, num_checks = 0;
    logic [23:0] tbl [0:16] = '{24'h405A5A, 24'hBFA5A5, 24'h02FF07, 24'h07FF03, 24'h09FFFE, 24'h3EFF07,
        24'h0BFF00, 24'h3FFF00, 24'h13FF3C, 24'h03FF17, 24'h2CFF90, 24'h06FFC3, 24'h0AFFAA, 24'h08FF06,
        24'h044848, 24'h007777, 24'h040000};
    initial begin
        forever #5 clk = ~clk;
    end
    mmm_memory_map dut_u (.CLK_I(clk), .RST_N_I(rst_n), .EXT_RESET_N_I(ext_n), .PIN_A_I(pin_a),
        .PIN_B_I(pin_b), .PIN_C_I(pin_c), .REQ_I(req), .FLAGS_I('0), .TIMEOUT_FLAG_I(1'b1),
        .POWER_DOWN_FLAG_I(1'b0), .PERIPH_I(periph), .PC_OP_I(pc_op), .PC_TARGET_I(target),
        .FETCH_ADDR_O(fetch_addr), .FETCH_VALID_O(fetch_valid), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
        .SFR_WR_O(sfr_wr), .PORT_O(port_out), .RESET_ACTIVE_O(reset_active));
    mmm_core_model core_u (.CLK_I(clk), .RD_DATA_I(rd_data), .RD_VALID_I(rd_valid), .REQ_O(req),
        .PC_OP_O(pc_op), .TARGET_O(target));
    task automatic end_sim();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_run();
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (fetch_valid === 1'b1) return;
        end
        miscompares++;
        end_sim();
    endtask : wait_run
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        core_u.read_byte(addr, d, ok);
        check("rd_valid", {10'h0, ok}, 11'h001);
        check("rd_data", {3'h0, d}, {3'h0, exp});
    endtask : rd_chk
    task automatic pc_go(input mmm_pc_op_t op, input logic [10:0] tgt, input logic [10:0] exp, input logic bub);
        core_u.flow(op, tgt);
        check("fetch_addr", fetch_addr, exp);
        check("fetch_valid", {10'h0, fetch_valid}, {10'h0, ~bub});
        @(negedge clk);
        check("fetch_valid", {10'h0, fetch_valid}, 11'h001);
    endtask : pc_go
    initial begin
        repeat (16) @(negedge clk);
        check("fetch_addr", fetch_addr, RESET_VECTOR);
        check("reset_active", {10'h0, reset_active}, 11'h001);
        check("fetch_valid", {10'h0, fetch_valid}, 11'h000);
        rst_n = 1'b1;
        wait_run();
        $display("test reset done");
        // Each entry: address, data written, value read back
        foreach (tbl[i]) begin
            core_u.write_byte(tbl[i][23:16], tbl[i][15:8]);
            rd_chk(tbl[i][23:16], tbl[i][7:0]);
        end
        check("port_a_dir", {3'h0, port_out.a_dir}, {3'h0, RST_DIR});
        check("port_b_dir", {3'h0, port_out.b_dir}, {3'h0, MASK_PB});
        check("port_c_dat", {3'h0, port_out.c_dat}, {3'h0, MASK_PC});
        core_u.write_byte(8'h00, 8'h11);
        check("wr_stb", {10'h0, sfr_wr.stb}, 11'h000);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h48, 8'h77);
        $display("test data map done");
        pc_go(MMM_PC_JUMP, 11'h7FF, 11'h7FF, 1'b1);
        pc_go(MMM_PC_STEP, 11'h000, 11'h000, 1'b0);
        pc_go(MMM_PC_IRQ, 11'h000, IRQ_VECTOR, 1'b1);
        pc_go(MMM_PC_RETI, 11'h000, 11'h000, 1'b1);
        pc_go(MMM_PC_JUMP, 11'h100, 11'h100, 1'b1);
        for (int i = 1; i <= 8; i++) pc_go(MMM_PC_CALL, 11'h100 + 11'(i * 16), 11'h100 + 11'(i * 16), 1'b1);
        for (int j = 7; j >= 0; j--) pc_go(MMM_PC_RET, 11'h000, 11'h101 + 11'(j * 16), 1'b1);
        $display("test program flow done");
        core_u.write_byte(8'h02, 8'h05);
        check("fetch_addr", fetch_addr, 11'h101);
        core_u.write_byte(8'h01, 8'h34);
        check("fetch_addr", fetch_addr, 11'h534);
        check("wr_stb", {10'h0, sfr_wr.stb}, 11'h001);
        check("wr_addr", {3'h0, sfr_wr.addr}, {3'h0, ADDR_PCL});
        check("wr_data", {3'h0, sfr_wr.data}, 11'h034);
        @(negedge clk);
        ext_n = 1'b0;
        repeat (4) @(negedge clk);
        check("reset_active", {10'h0, reset_active}, 11'h001);
        check("fetch_addr", fetch_addr, RESET_VECTOR);
        ext_n = 1'b1;
        wait_run();
        check("fetch_addr", fetch_addr, RESET_VECTOR);
        $display("test pin reset done");
        end_sim();
    end
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
